// ===== rtl/prsf_rx_framer.sv
`timescale 1ns/1ns
`default_nettype none
module prsf_rx_framer (
    // Clock and reset.
    input  wire logic                             clk_sys,
    input  wire logic                             reset_n,
    // Received doublewords from the link side.
    input  wire prsf_pkg::prsf_dword_t            up_dword,
    input  wire logic                             up_valid,
    output logic                                  up_ready,
    // Beat stream to the user application.
    output logic [prsf_pkg::PAYLOAD_W-1:0]        rx_payload,
    output logic [prsf_pkg::KEEP_W-1:0]           rx_byte_keep,
    output logic                                  rx_final_beat,
    output prsf_pkg::prsf_sideband_t              rx_sideband,
    output logic                                  rx_beat_valid,
    input  wire logic                             rx_sink_ready,
    // AXI4-Lite register slave.
    input  wire logic [prsf_pkg::ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [prsf_pkg::ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    // Interrupt.
    output logic                                  irq
);

    function automatic logic addr_known(input logic [prsf_pkg::ADDR_W-1:0] a);
        return a == prsf_pkg::REG_CTRL || a == prsf_pkg::REG_STATUS ||
               a == prsf_pkg::REG_IRQ_STATUS ||
               a == prsf_pkg::REG_IRQ_MASK || a == prsf_pkg::REG_PKT_COUNT;
    endfunction

    function automatic logic [4:0] end_code(input logic [1:0] lane);
        return {prsf_pkg::EOF_FLAG, lane, prsf_pkg::DW_LAST_BYTE};
    endfunction

    // Beat assembly state.
    logic [prsf_pkg::PAYLOAD_W-1:0] asm_data;
    logic [prsf_pkg::PAYLOAD_W-1:0] next_asm_data;
    logic [2:0]                     asm_lane;
    logic [2:0]                     next_asm_lane;
    logic [4:0]                     asm_sof;
    logic [4:0]                     next_asm_sof;
    logic [1:0]                     asm_end_lane;
    logic [1:0]                     next_asm_end_lane;
    logic                           asm_eof;
    logic                           next_asm_eof;
    logic                           asm_poison;
    logic                           next_asm_poison;
    logic                           asm_ecrc;
    logic                           next_asm_ecrc;
    logic                           asm_full;
    logic                           next_asm_full;
    logic                           asm_wait;
    logic                           next_asm_wait;

    // Output beat state.
    logic [prsf_pkg::PAYLOAD_W-1:0] next_rx_payload;
    logic [prsf_pkg::KEEP_W-1:0]    next_rx_byte_keep;
    logic                           next_rx_final_beat;
    prsf_pkg::prsf_sideband_t       next_rx_sideband;
    logic                           next_rx_beat_valid;

    // Register state.
    logic [1:0]                     ctrl;
    logic [1:0]                     next_ctrl;
    logic [prsf_pkg::IRQ_W-1:0]     irq_status;
    logic [prsf_pkg::IRQ_W-1:0]     next_irq_status;
    logic [prsf_pkg::IRQ_W-1:0]     irq_mask;
    logic [prsf_pkg::IRQ_W-1:0]     next_irq_mask;
    logic [31:0]                    pkt_count;
    logic [31:0]                    next_pkt_count;
    logic [1:0]                     next_bresp;
    logic                           next_bvalid;
    logic [31:0]                    next_rdata;
    logic [1:0]                     next_rresp;
    logic                           next_rvalid;

    logic                           wide;
    logic                           take;
    logic                           move;
    logic                           xfer;
    logic                           wr_go;
    logic                           rd_go;
    logic [1:0]                     idx;
    logic [2:0]                     beat_lanes;
    logic [prsf_pkg::IRQ_W-1:0]     events;
    logic [prsf_pkg::IRQ_W-1:0]     clr;

    assign wide       = ctrl[prsf_pkg::CTRL_WIDE];
    assign beat_lanes = wide ? prsf_pkg::LANES_WIDE : prsf_pkg::LANES_NARROW;
    assign idx        = asm_wait ? prsf_pkg::LANE_STRADDLE : asm_lane[1:0];
    // After an early end in a wide beat only a new start may share it.
    assign up_ready   = ctrl[prsf_pkg::CTRL_ENABLE] && !asm_full &&
                        (!asm_wait || (up_valid && up_dword.sop));
    assign take       = up_valid && up_ready;
    assign xfer       = rx_beat_valid && rx_sink_ready;
    assign move       = asm_full && (!rx_beat_valid || rx_sink_ready);

    always_comb begin
        next_asm_data     = asm_data;
        next_asm_lane     = asm_lane;
        next_asm_sof      = asm_sof;
        next_asm_end_lane = asm_end_lane;
        next_asm_eof      = asm_eof;
        next_asm_poison   = asm_poison;
        next_asm_ecrc     = asm_ecrc;
        next_asm_full     = asm_full;
        next_asm_wait     = asm_wait;
        if (move) begin
            next_asm_data   = '0;
            next_asm_lane   = '0;
            next_asm_sof    = prsf_pkg::SOF_NONE;
            next_asm_eof    = 1'b0;
            next_asm_ecrc   = 1'b0;
            next_asm_full   = 1'b0;
            // A packet that began in the straddle half is still open.
            next_asm_poison = (asm_eof &&
                              !(asm_sof == prsf_pkg::SOF_BYTE8 &&
                                asm_end_lane < prsf_pkg::LANE_STRADDLE)) ?
                              1'b0 : asm_poison;
        end else if (asm_wait && !(up_valid && up_dword.sop)) begin
            next_asm_full = 1'b1;
            next_asm_wait = 1'b0;
        end
        if (take) begin
            next_asm_wait = 1'b0;
            for (int i = 0; i < prsf_pkg::LANES; i++) begin
                if (idx == i[1:0]) begin
                    next_asm_data[i*prsf_pkg::DW_W +: prsf_pkg::DW_W] =
                        up_dword.dw;
                end
            end
            if (up_dword.sop) begin
                next_asm_sof = (idx == prsf_pkg::LANE_STRADDLE) ?
                               prsf_pkg::SOF_BYTE8 : prsf_pkg::SOF_BYTE0;
                next_asm_poison = up_dword.poison;
            end
            next_asm_lane = {1'b0, idx} + 3'h1;
            if (up_dword.eop) begin
                next_asm_eof      = 1'b1;
                next_asm_end_lane = idx;
                next_asm_ecrc     = up_dword.ecrc_err;
                if (wide && idx < prsf_pkg::LANE_STRADDLE) begin
                    next_asm_wait = 1'b1;
                end else begin
                    next_asm_full = 1'b1;
                end
            end else if (next_asm_lane == beat_lanes) begin
                next_asm_full = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            asm_data     <= '0;
            asm_lane     <= '0;
            asm_sof      <= prsf_pkg::SOF_NONE;
            asm_end_lane <= '0;
            asm_eof      <= 1'b0;
            asm_poison   <= 1'b0;
            asm_ecrc     <= 1'b0;
            asm_full     <= 1'b0;
            asm_wait     <= 1'b0;
        end else begin
            asm_data     <= next_asm_data;
            asm_lane     <= next_asm_lane;
            asm_sof      <= next_asm_sof;
            asm_end_lane <= next_asm_end_lane;
            asm_eof      <= next_asm_eof;
            asm_poison   <= next_asm_poison;
            asm_ecrc     <= next_asm_ecrc;
            asm_full     <= next_asm_full;
            asm_wait     <= next_asm_wait;
        end
    end

    // A stalled beat keeps every field; only a move loads new ones.
    always_comb begin
        next_rx_payload    = rx_payload;
        next_rx_byte_keep  = rx_byte_keep;
        next_rx_final_beat = rx_final_beat;
        next_rx_sideband   = rx_sideband;
        next_rx_beat_valid = rx_beat_valid && !rx_sink_ready;
        if (move) begin
            next_rx_beat_valid = 1'b1;
            next_rx_payload    = asm_data;
            next_rx_final_beat = asm_eof;
            next_rx_byte_keep  = prsf_pkg::KEEP_ALL;
            if (!wide && asm_eof && asm_end_lane == '0) begin
                next_rx_byte_keep = prsf_pkg::KEEP_LOW;
            end
            next_rx_sideband = '0;
            next_rx_sideband.start_marker =
                wide ? asm_sof : prsf_pkg::SOF_NONE;
            next_rx_sideband.end_marker = (wide && asm_eof) ?
                end_code(asm_end_lane) : prsf_pkg::EOF_NONE;
            next_rx_sideband.poisoned  = asm_poison;
            next_rx_sideband.crc_fault = asm_eof && asm_ecrc;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_payload    <= '0;
            rx_byte_keep  <= prsf_pkg::KEEP_ALL;
            rx_final_beat <= 1'b0;
            rx_sideband   <= '0;
            rx_beat_valid <= 1'b0;
        end else begin
            rx_payload    <= next_rx_payload;
            rx_byte_keep  <= next_rx_byte_keep;
            rx_final_beat <= next_rx_final_beat;
            rx_sideband   <= next_rx_sideband;
            rx_beat_valid <= next_rx_beat_valid;
        end
    end

    // Register slave: a write needs address and data in the same cycle.
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    always_comb begin
        events = '0;
        events[prsf_pkg::IRQ_POISON] = xfer && rx_sideband.poisoned;
        events[prsf_pkg::IRQ_ECRC]   = xfer && rx_sideband.crc_fault;
        events[prsf_pkg::IRQ_PKT]    = xfer && rx_final_beat;
        clr = '0;
        if (wr_go && s_axi_wstrb[0] &&
            s_axi_awaddr == prsf_pkg::REG_IRQ_STATUS) begin
            clr = s_axi_wdata[prsf_pkg::IRQ_W-1:0];
        end
    end

    always_comb begin
        next_ctrl       = ctrl;
        next_irq_mask   = irq_mask;
        next_irq_status = (irq_status & ~clr) | events;
        next_pkt_count  = pkt_count + {31'h0, events[prsf_pkg::IRQ_PKT]};
        next_bresp      = s_axi_bresp;
        next_bvalid     = s_axi_bvalid && !s_axi_bready;
        next_rdata      = s_axi_rdata;
        next_rresp      = s_axi_rresp;
        next_rvalid     = s_axi_rvalid && !s_axi_rready;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp  = addr_known(s_axi_awaddr) ?
                          prsf_pkg::RESP_OKAY : prsf_pkg::RESP_SLVERR;
            if (s_axi_wstrb[0] && s_axi_awaddr == prsf_pkg::REG_CTRL) begin
                next_ctrl = s_axi_wdata[1:0];
            end
            if (s_axi_wstrb[0] && s_axi_awaddr == prsf_pkg::REG_IRQ_MASK) begin
                next_irq_mask = s_axi_wdata[prsf_pkg::IRQ_W-1:0];
            end
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp  = addr_known(s_axi_araddr) ?
                          prsf_pkg::RESP_OKAY : prsf_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                prsf_pkg::REG_CTRL:       next_rdata = {30'h0, ctrl};
                prsf_pkg::REG_STATUS:     next_rdata = {29'h0, asm_wait,
                                                        asm_full,
                                                        rx_beat_valid};
                prsf_pkg::REG_IRQ_STATUS: next_rdata = {29'h0, irq_status};
                prsf_pkg::REG_IRQ_MASK:   next_rdata = {29'h0, irq_mask};
                prsf_pkg::REG_PKT_COUNT:  next_rdata = pkt_count;
                default:                  next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl         <= prsf_pkg::CTRL_RESET;
            irq_status   <= '0;
            irq_mask     <= '0;
            pkt_count    <= 32'h0;
            s_axi_bresp  <= prsf_pkg::RESP_OKAY;
            s_axi_bvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= prsf_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
        end else begin
            ctrl         <= next_ctrl;
            irq_status   <= next_irq_status;
            irq_mask     <= next_irq_mask;
            pkt_count    <= next_pkt_count;
            s_axi_bresp  <= next_bresp;
            s_axi_bvalid <= next_bvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
            s_axi_rvalid <= next_rvalid;
        end
    end

    assign irq = |(irq_status & irq_mask);

endmodule
`default_nettype wire

// ===== pkg/prsf_pkg.sv
// Notes on behaviour
// - Beat valid only with real packet data.
// - Beat moves when valid and ready both high.
// - Keep bit n qualifies payload byte n.
// - Non-final beats drive keep all ones.
// - 64-bit final beat keep 0x0F or 0xFF.
// - Start marker sits in sideband bits 14:10.
// - Start marker: top bit flag, low bits position.
// - Start marker: byte 0, byte 8, or zero.
// - End marker sits in sideband bits 21:17.
// - End marker: top bit flag, low bits position.
// - End position only bytes 3, 7, 11, 15.
// - No end: marker reads 5'b01111.
// - 64-bit: poison flag high whole packet.
// - 128-bit straddle: poison follows starting packet.
// - CRC fault flag on the packet's ending beat.
package prsf_pkg;

    localparam int DW_W      = 32;
    localparam int LANES     = 4;
    localparam int PAYLOAD_W = DW_W * LANES;
    localparam int KEEP_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int IRQ_W     = 3;

    localparam logic [2:0] LANES_WIDE    = 3'h4;
    localparam logic [2:0] LANES_NARROW  = 3'h2;
    localparam logic [1:0] LANE_STRADDLE = 2'h2;

    localparam logic [KEEP_W-1:0] KEEP_ALL = 8'hff;
    localparam logic [KEEP_W-1:0] KEEP_LOW = 8'h0f;

    localparam logic [4:0] SOF_NONE  = 5'h00;
    localparam logic [4:0] SOF_BYTE0 = 5'h10;
    localparam logic [4:0] SOF_BYTE8 = 5'h18;
    localparam logic [4:0] EOF_NONE  = 5'h0f;
    localparam logic [0:0] EOF_FLAG  = 1'h1;
    localparam logic [1:0] DW_LAST_BYTE = 2'h3;

    localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_PKT_COUNT  = 8'h10;

    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_WIDE   = 1;
    localparam int IRQ_POISON  = 0;
    localparam int IRQ_ECRC    = 1;
    localparam int IRQ_PKT     = 2;

    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [DW_W-1:0] dw;
        logic            sop;
        logic            eop;
        logic            poison;
        logic            ecrc_err;
    } prsf_dword_t;

    typedef struct packed {
        logic [4:0] end_marker;
        logic [1:0] rsvd_hi;
        logic [4:0] start_marker;
        logic [7:0] rsvd_lo;
        logic       poisoned;
        logic       crc_fault;
    } prsf_sideband_t;

endpackage

// ===== testbench/prsf_rx_framer_chk.sv
`timescale 1ns/1ns
`default_nettype none
module prsf_rx_framer_chk (
    // Watched stream ports.
    input wire logic                           clk_sys,
    input wire logic                           reset_n,
    input wire logic [prsf_pkg::PAYLOAD_W-1:0] rx_payload,
    input wire logic [prsf_pkg::KEEP_W-1:0]    rx_byte_keep,
    input wire logic                           rx_final_beat,
    input wire prsf_pkg::prsf_sideband_t       rx_sideband,
    input wire logic                           rx_beat_valid,
    input wire logic                           rx_sink_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_stall;
        rx_beat_valid && !rx_sink_ready;
    endsequence
    sequence s_held;
        rx_beat_valid && $stable(rx_payload) && $stable(rx_byte_keep)
            && $stable(rx_final_beat) && $stable(rx_sideband);
    endsequence
    property p_hold;
        s_stall |=> s_held;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Stalled beat changed.");
    property p_drop;
        $fell(rx_beat_valid) |-> $past(rx_sink_ready);
    endproperty
    a_drop: assert property (p_drop)
        else $error("Beat withdrawn without transfer.");
    property p_reset;
        $rose(reset_n) |-> !rx_beat_valid;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Beat valid right after reset.");
    property p_keep_mid;
        rx_beat_valid && !rx_final_beat |-> rx_byte_keep == 8'hff;
    endproperty
    a_keep_mid: assert property (p_keep_mid)
        else $error("Partial keep on inner beat.");
    property p_keep_end;
        rx_beat_valid && rx_final_beat |-> rx_byte_keep inside {8'hff, 8'h0f};
    endproperty
    a_keep_end: assert property (p_keep_end)
        else $error("Bad keep on final beat.");
    property p_short;
        rx_beat_valid && rx_byte_keep == 8'h0f |-> rx_payload[127:32] == 0;
    endproperty
    a_short: assert property (p_short)
        else $error("Unused lanes not zero.");
    property p_start;
        rx_beat_valid |-> rx_sideband.start_marker inside {5'h00, 5'h10, 5'h18};
    endproperty
    a_start: assert property (p_start)
        else $error("Bad start marker.");
    property p_end_pos;
        rx_beat_valid && rx_sideband.end_marker[4]
            |-> rx_sideband.end_marker[1:0] == 2'h3;
    endproperty
    a_end_pos: assert property (p_end_pos)
        else $error("End not on a doubleword edge.");
    property p_no_end;
        rx_beat_valid && !rx_final_beat |-> rx_sideband.end_marker == 5'h0f;
    endproperty
    a_no_end: assert property (p_no_end)
        else $error("End marker on inner beat.");
    property p_crc;
        rx_beat_valid && rx_sideband.crc_fault |-> rx_final_beat;
    endproperty
    a_crc: assert property (p_crc)
        else $error("Fault flag off the ending beat.");
endmodule
bind prsf_rx_framer prsf_rx_framer_chk i_chk (
    .clk_sys, .reset_n, .rx_payload, .rx_byte_keep,
    .rx_final_beat, .rx_sideband, .rx_beat_valid, .rx_sink_ready
);
`default_nettype wire

// ===== testbench/prsf_user_sink.sv
`timescale 1ns/1ns
`default_nettype none
module prsf_user_sink (
    // Clock, reset and pacing.
    input wire logic                     clk_sys,
    input wire logic                     reset_n,
    input wire logic                     stall,
    // Beat stream.
    input wire logic [127:0]             rx_payload,
    input wire logic [7:0]               rx_byte_keep,
    input wire logic                     rx_final_beat,
    input wire prsf_pkg::prsf_sideband_t rx_sideband,
    input wire logic                     rx_beat_valid,
    output logic                         rx_sink_ready
);
    logic [158:0] beats [$];
    logic [1:0]   phase;
    // When stalling, accept only one cycle in four.
    assign rx_sink_ready = !stall || phase == 2'h0;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
            if (rx_beat_valid && rx_sink_ready) begin
                beats.push_back({rx_final_beat, rx_byte_keep, rx_sideband,
                                 rx_payload});
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/prsf_rx_framer_test.sv
`timescale 1ns/1ns
`default_nettype none
module prsf_rx_framer_test;
    logic clk_sys, reset_n, up_valid, up_ready, rx_final_beat, irq, stall;
    logic rx_beat_valid, rx_sink_ready, s_axi_awvalid, s_axi_awready;
    logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte_keep;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [127:0] rx_payload;
    prsf_pkg::prsf_dword_t up_dword;
    prsf_pkg::prsf_sideband_t rx_sideband;
    int n_errors, num_checks;
    prsf_rx_framer i_dut (.clk_sys, .reset_n, .up_dword, .up_valid,
        .up_ready, .rx_payload, .rx_byte_keep, .rx_final_beat, .rx_sideband,
        .rx_beat_valid, .rx_sink_ready, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    prsf_user_sink i_sink (.clk_sys, .reset_n, .stall, .rx_payload,
        .rx_byte_keep, .rx_final_beat, .rx_sideband, .rx_beat_valid,
        .rx_sink_ready);
    always #5 clk_sys = ~clk_sys;
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [158:0] got, input logic [158:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge clk_sys);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        tb = 1'b0;
        for (int n = 0; n < 40 && !tb; n++) begin
            #1;
            ta = s_axi_awready; tw = s_axi_wready; tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
        if (!tb) hang();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge clk_sys);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        tr = 1'b0;
        for (int n = 0; n < 40 && !tr; n++) begin
            #1;
            ta = s_axi_arready; tr = s_axi_rvalid;
            d = s_axi_rdata; r = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
        if (!tr) hang();
    endtask
    task automatic send_pkt(input int n, input logic [31:0] b,
                            input logic p, input logic c);
        logic t;
        for (int k = 0; k < n; k++) begin
            up_dword <= {b + k, k == 0, k == n - 1, p, c};
            up_valid <= 1'b1;
            t = 1'b0;
            for (int i = 0; i < 60 && !t; i++) begin
                #1;
                t = up_ready;
                @(posedge clk_sys);
            end
            if (!t) hang();
        end
    endtask
    task automatic wait_beats(input int n);
        up_valid <= 1'b0;
        up_dword <= ~up_dword;
        for (int i = 0; i < 200 && i_sink.beats.size() < n; i++)
            @(posedge clk_sys);
        if (i_sink.beats.size() < n) hang();
    endtask
    function automatic logic [158:0] bt(logic f, logic [7:0] k,
        logic [4:0] e, logic [4:0] s, logic p, logic c, logic [127:0] v);
        return {f, k, e, 2'h0, s, 8'h00, p, c, v};
    endfunction
    task automatic test_regs();
        axi_rd(prsf_pkg::REG_CTRL);
        check({r, d}, 34'h0);
        axi_rd(prsf_pkg::REG_PKT_COUNT);
        check({r, d}, 34'h0);
        axi_rd(8'h20);
        check({r, d}, {prsf_pkg::RESP_SLVERR, 32'h0});
        axi_wr(8'h20, 32'h1);
        check(r, prsf_pkg::RESP_SLVERR);
    endtask
    task automatic test_narrow();
        stall <= 1'b1;
        axi_wr(prsf_pkg::REG_CTRL, 32'h1);
        check(r, prsf_pkg::RESP_OKAY);
        send_pkt(3, 32'ha0, 1'b1, 1'b1);
        wait_beats(2);
        check(i_sink.beats[0], bt(0, 8'hff, 5'h0f, 5'h00, 1, 0,
              {64'h0, 32'ha1, 32'ha0}));
        check(i_sink.beats[1], bt(1, 8'h0f, 5'h0f, 5'h00, 1, 1,
              {96'h0, 32'ha2}));
        axi_rd(prsf_pkg::REG_IRQ_STATUS);
        check({r, d}, 34'h7);
        check(irq, 1'b0);
        axi_wr(prsf_pkg::REG_IRQ_MASK, 32'h7);
        check(irq, 1'b1);
        axi_wr(prsf_pkg::REG_IRQ_STATUS, 32'h7);
        check(irq, 1'b0);
        i_sink.beats.delete();
    endtask
    task automatic test_wide();
        stall <= 1'b0;
        axi_wr(prsf_pkg::REG_CTRL, 32'h3);
        send_pkt(4, 32'hb0, 1'b0, 1'b0);
        send_pkt(6, 32'hc0, 1'b0, 1'b1);
        send_pkt(4, 32'hd0, 1'b1, 1'b0);
        wait_beats(4);
        check(i_sink.beats[0], bt(1, 8'hff, 5'h1f, 5'h10, 0, 0,
              {32'hb3, 32'hb2, 32'hb1, 32'hb0}));
        check(i_sink.beats[1], bt(0, 8'hff, 5'h0f, 5'h10, 0, 0,
              {32'hc3, 32'hc2, 32'hc1, 32'hc0}));
        check(i_sink.beats[2], bt(1, 8'hff, 5'h17, 5'h18, 1, 1,
              {32'hd1, 32'hd0, 32'hc5, 32'hc4}));
        check(i_sink.beats[3], bt(1, 8'hff, 5'h17, 5'h00, 1, 0,
              {64'h0, 32'hd3, 32'hd2}));
        axi_rd(prsf_pkg::REG_PKT_COUNT);
        check({r, d}, 34'h4);
        axi_rd(prsf_pkg::REG_STATUS);
        check({r, d}, 34'h0);
    endtask
    initial begin
        clk_sys = 1'b0; reset_n = 1'b0; up_valid = 1'b0; up_dword = '0;
        stall = 1'b0; s_axi_awaddr = '0; s_axi_awvalid = 1'b0;
        s_axi_wdata = '0; s_axi_wstrb = '0; s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0; s_axi_araddr = '0; s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0; n_errors = 0; num_checks = 0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        test_regs();
        test_narrow();
        test_wide();
        report_and_stop();
    end
endmodule
`default_nettype wire
